// File: hw/tcp_dev.sv
`timescale 1ns/1ps
module tcp_dev (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Bus
    tcp_i2c_if.dev          bus,
    // Address setting
    input  wire logic       nvm_addr_valid,
    input  wire logic [6:0] nvm_addr,
    // Core status
    input  wire logic       phase_tick,
    input  wire logic [7:0] irq_events,
    input  wire logic [7:0] cap_stat,
    input  wire logic [15:0] wheel_pos,
    input  wire logic [7:0] gpi_stat,
    input  wire logic [7:0] spm_stat,
    // Applied controls and interrupt output
    output logic [7:0]      op_mode,
    output logic [7:0]      gpo_ctrl,
    output logic [7:0]      gpp_id,
    output logic [7:0]      gpp_intensity,
    output logic [7:0]      spm_cfg,
    output logic [7:0]      spm_base,
    output logic [15:0]     spm_key,
    output logic [7:0]      soft_reset,
    output logic            interrupt_output_n
);
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_AACK, ST_WBYTE, ST_WACK, ST_RBYTE, ST_RACK, ST_SKIP} tcp_st_t;
    tcp_st_t     st_ff;
    logic [1:0]  scl_s_ff;
    logic [1:0]  sda_s_ff;
    logic [3:0]  cnt_ff;
    logic [7:0]  sh_ff;
    logic [7:0]  ptr_ff;
    logic        have_ptr_ff;
    logic        oe_n_ff;
    logic [6:0]  addr_ff;
    logic [7:0]  irq_ff;
    logic        irq_n_ff;
    logic [7:0]  shadow_ff [tcp_pkg::NUM_CTRL];
    logic [7:0]  live_ff [tcp_pkg::NUM_CTRL];
    logic        pend_ff;
    logic [7:0]  soft_rst_sh_ff;
    logic [7:0]  key_lsb_sh_ff;
    // =========================================================
    // Bus edge detection on the sampled pins
    // =========================================================
    wire scl_rise = scl_s_ff[0] && !scl_s_ff[1];
    wire scl_fall = !scl_s_ff[0] && scl_s_ff[1];
    wire start_c  = scl_s_ff[0] && scl_s_ff[1] && !sda_s_ff[0] && sda_s_ff[1];
    wire stop_c   = scl_s_ff[0] && scl_s_ff[1] && sda_s_ff[0] && !sda_s_ff[1];
    wire [7:0] shin = {sh_ff[6:0], sda_s_ff[0]};
    // =========================================================
    // Register decode
    // =========================================================
    wire [2:0] cidx = (ptr_ff == tcp_pkg::REG_OP_MODE)  ? 3'h0 :
                      (ptr_ff == tcp_pkg::REG_GPO_CTRL) ? 3'h1 :
                      (ptr_ff == tcp_pkg::REG_GPP_ID)   ? 3'h2 :
                      (ptr_ff == tcp_pkg::REG_GPP_INT)  ? 3'h3 :
                      (ptr_ff == tcp_pkg::REG_SPM_CFG)  ? 3'h4 :
                      (ptr_ff == tcp_pkg::REG_SPM_BASE) ? 3'h5 :
                      (ptr_ff == tcp_pkg::REG_KEY_MSB)  ? 3'h6 : 3'h7;
    wire is_ctrl = (ptr_ff >= tcp_pkg::REG_OP_MODE && ptr_ff <= tcp_pkg::REG_SPM_BASE) ||
                   ptr_ff == tcp_pkg::REG_KEY_MSB || ptr_ff == tcp_pkg::REG_KEY_LSB ||
                   ptr_ff == tcp_pkg::REG_SOFT_RST;
    wire [2:0] cidx_w = (ptr_ff == tcp_pkg::REG_KEY_LSB) ? 3'h7 : cidx;
    // Soft reset shares slot 7 with key lsb, so both use their own shadow registers
    wire [7:0] rd_val = (ptr_ff == tcp_pkg::REG_IRQ_SRC)  ? irq_ff :
                        (ptr_ff == tcp_pkg::REG_CAP_STAT) ? cap_stat :
                        (ptr_ff == tcp_pkg::REG_POS_MSB)  ? wheel_pos[15:8] :
                        (ptr_ff == tcp_pkg::REG_POS_LSB)  ? wheel_pos[7:0] :
                        (ptr_ff == tcp_pkg::REG_GPI_STAT) ? gpi_stat :
                        (ptr_ff == tcp_pkg::REG_SPM_STAT) ? spm_stat :
                        (ptr_ff == tcp_pkg::REG_SOFT_RST) ? soft_rst_sh_ff :
                        (ptr_ff == tcp_pkg::REG_KEY_LSB)  ? key_lsb_sh_ff :
                        is_ctrl ? shadow_ff[cidx] : 8'h00;
    wire wr_stb  = (st_ff == ST_WBYTE) && scl_rise && cnt_ff == 4'h7 && have_ptr_ff;
    wire rd_load = ((st_ff == ST_AACK) && scl_fall && !oe_n_ff && sh_ff[0]) ||
                   ((st_ff == ST_RACK) && scl_rise && !sda_s_ff[0]);
    wire irq_read = rd_load && ptr_ff == tcp_pkg::REG_IRQ_SRC;
    // =========================================================
    // Protocol engine
    // =========================================================
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_s_ff    <= 2'h3;
            sda_s_ff    <= 2'h3;
            st_ff       <= ST_IDLE;
            cnt_ff      <= 4'h0;
            sh_ff       <= 8'h00;
            ptr_ff      <= 8'h00;
            have_ptr_ff <= 1'b0;
            oe_n_ff     <= 1'b1;
        end else begin
            scl_s_ff <= {scl_s_ff[0], bus.scl};
            sda_s_ff <= {sda_s_ff[0], bus.sda};
            if (stop_c) begin
                st_ff   <= ST_IDLE;
                oe_n_ff <= 1'b1;
            end else if (start_c) begin
                st_ff   <= ST_ADDR;
                cnt_ff  <= 4'h0;
                oe_n_ff <= 1'b1;
            end else begin
                case (st_ff)
                    ST_ADDR: if (scl_rise) begin
                        sh_ff  <= shin;
                        cnt_ff <= cnt_ff + 4'h1;
                        if (cnt_ff == 4'h7) begin
                            if (shin[7:1] == addr_ff) st_ff <= ST_AACK;
                            else st_ff <= ST_SKIP;
                        end
                    end
                    ST_AACK: if (scl_fall) begin
                        if (oe_n_ff) begin
                            oe_n_ff <= 1'b0;
                        end else if (sh_ff[0]) begin
                            st_ff   <= ST_RBYTE;
                            sh_ff   <= rd_val;
                            oe_n_ff <= rd_val[7];
                            cnt_ff  <= 4'h1;
                            ptr_ff  <= ptr_ff + 8'h01;
                        end else begin
                            st_ff       <= ST_WBYTE;
                            have_ptr_ff <= 1'b0;
                            oe_n_ff     <= 1'b1;
                            cnt_ff      <= 4'h0;
                        end
                    end
                    ST_WBYTE: if (scl_rise) begin
                        sh_ff  <= shin;
                        cnt_ff <= cnt_ff + 4'h1;
                        if (cnt_ff == 4'h7) begin
                            st_ff <= ST_WACK;
                            if (!have_ptr_ff) begin
                                ptr_ff      <= shin;
                                have_ptr_ff <= 1'b1;
                            end else begin
                                ptr_ff <= ptr_ff + 8'h01;
                            end
                        end
                    end
                    ST_WACK: if (scl_fall) begin
                        if (oe_n_ff) oe_n_ff <= 1'b0;
                        else begin
                            oe_n_ff <= 1'b1;
                            st_ff   <= ST_WBYTE;
                            cnt_ff  <= 4'h0;
                        end
                    end
                    ST_RBYTE: if (scl_fall) begin
                        if (cnt_ff == 4'h8) begin
                            oe_n_ff <= 1'b1;
                            st_ff   <= ST_RACK;
                        end else begin
                            oe_n_ff <= sh_ff[7 - cnt_ff[2:0]];
                            cnt_ff  <= cnt_ff + 4'h1;
                        end
                    end
                    ST_RACK: if (scl_rise) begin
                        if (!sda_s_ff[0]) begin
                            st_ff  <= ST_RBYTE;
                            sh_ff  <= rd_val;
                            cnt_ff <= 4'h0;
                            ptr_ff <= ptr_ff + 8'h01;
                        end else st_ff <= ST_SKIP;
                    end
                    ST_IDLE, ST_SKIP: ;
                    default: st_ff <= ST_IDLE;
                endcase
            end
        end
    end
    // =========================================================
    // Address selection, interrupt flags, controls
    // =========================================================
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_ff  <= tcp_pkg::DEF_SLAVE_ADDR;
            irq_ff   <= 8'h00;
            irq_n_ff <= 1'b1;
            pend_ff  <= 1'b0;
            soft_rst_sh_ff <= 8'h00;
            key_lsb_sh_ff  <= 8'h00;
            soft_reset     <= 8'h00;
            for (int i = 0; i < tcp_pkg::NUM_CTRL; i++) begin
                shadow_ff[i] <= 8'h00;
                live_ff[i]   <= 8'h00;
            end
        end else begin
            if (st_ff == ST_IDLE) addr_ff <= nvm_addr_valid ? nvm_addr : tcp_pkg::DEF_SLAVE_ADDR;
            irq_ff   <= (irq_read ? 8'h00 : irq_ff) | irq_events;
            irq_n_ff <= ~|((irq_read ? 8'h00 : irq_ff) | irq_events);
            if (wr_stb && is_ctrl) begin
                if (ptr_ff == tcp_pkg::REG_SOFT_RST) soft_rst_sh_ff <= shin;
                else if (ptr_ff == tcp_pkg::REG_KEY_LSB) key_lsb_sh_ff <= shin;
                else shadow_ff[cidx_w] <= shin;
                pend_ff <= 1'b1;
            end else if (phase_tick) begin
                pend_ff <= 1'b0;
            end
            if (phase_tick && pend_ff) begin
                for (int i = 0; i < 6; i++) live_ff[i] <= shadow_ff[i];
                live_ff[6] <= shadow_ff[6];
                live_ff[7] <= key_lsb_sh_ff;
                soft_reset <= soft_rst_sh_ff;
            end
        end
    end
    assign bus.sda_dev_oe_n = oe_n_ff;
    assign op_mode          = live_ff[0];
    assign gpo_ctrl         = live_ff[1];
    assign gpp_id           = live_ff[2];
    assign gpp_intensity    = live_ff[3];
    assign spm_cfg          = live_ff[4];
    assign spm_base         = live_ff[5];
    assign spm_key          = {live_ff[6], live_ff[7]};
    assign interrupt_output_n = irq_n_ff;
endmodule : tcp_dev

// File: shared/tcp_pkg.sv
package tcp_pkg;
    // =========================================================
    // Bus and addressing
    // =========================================================
    localparam logic [6:0] DEF_SLAVE_ADDR = 7'h2B;
    localparam logic [7:0] NVM_ADDR_LOC   = 8'h04;
    localparam int         CLK_HZ         = 40000000;
    localparam int         STD_BPS        = 100000;
    localparam int         FAST_BPS       = 400000;
    // Host divider: four phases per bit, rounded up to stay within rate
    localparam int         STD_QDIV       = (CLK_HZ + 4 * STD_BPS - 1) / (4 * STD_BPS);
    localparam int         FAST_QDIV      = (CLK_HZ + 4 * FAST_BPS - 1) / (4 * FAST_BPS);
    // =========================================================
    // Register map
    // =========================================================
    localparam logic [7:0] REG_IRQ_SRC    = 8'h00;
    localparam logic [7:0] REG_CAP_STAT   = 8'h01;
    localparam logic [7:0] REG_POS_MSB    = 8'h03;
    localparam logic [7:0] REG_POS_LSB    = 8'h04;
    localparam logic [7:0] REG_GPI_STAT   = 8'h07;
    localparam logic [7:0] REG_SPM_STAT   = 8'h08;
    localparam logic [7:0] REG_OP_MODE    = 8'h09;
    localparam logic [7:0] REG_GPO_CTRL   = 8'h0A;
    localparam logic [7:0] REG_GPP_ID     = 8'h0B;
    localparam logic [7:0] REG_GPP_INT    = 8'h0C;
    localparam logic [7:0] REG_SPM_CFG    = 8'h0D;
    localparam logic [7:0] REG_SPM_BASE   = 8'h0E;
    localparam logic [7:0] REG_KEY_MSB    = 8'hAC;
    localparam logic [7:0] REG_KEY_LSB    = 8'hAD;
    localparam logic [7:0] REG_SOFT_RST   = 8'hB1;
    localparam int         NUM_CTRL       = 8;
    localparam int         FIFO_DEPTH     = 16;
    localparam int         FIFO_AW        = 4;
endpackage : tcp_pkg

// File: shared/tcp_i2c_if.sv
`timescale 1ns/1ps
interface tcp_i2c_if;
    logic scl_o_n_oe;
    logic sda_host_oe_n;
    logic sda_dev_oe_n;
    // Open drain wired-AND; outputs are always low when enabled
    wire  scl = ~scl_o_n_oe ? 1'b0 : 1'b1;
    wire  sda = (~sda_host_oe_n | ~sda_dev_oe_n) ? 1'b0 : 1'b1;
    modport dev  (input scl, input sda, output sda_dev_oe_n);
    modport host (input scl, input sda, output scl_o_n_oe, output sda_host_oe_n);
endinterface : tcp_i2c_if

// File: hw/tcp_fifo.sv
`timescale 1ns/1ps
module tcp_fifo #(
    parameter int W = 8,
    parameter int D = 16,
    parameter int AW = 4
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Fill side
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    // Drain side
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    logic [W-1:0] mem_ff [D];
    logic [AW:0]  wp_ff;
    logic [AW:0]  rp_ff;
    wire          full  = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    wire          empty = (wp_ff == rp_ff);
    wire          push  = in_valid && !full;
    wire          pop   = out_valid && out_ready;
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_ff[rp_ff[AW-1:0]];
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            if (push) begin
                mem_ff[wp_ff[AW-1:0]] <= in_data;
                wp_ff <= wp_ff + 1'b1;
            end
            if (pop) begin
                rp_ff <= rp_ff + 1'b1;
            end
        end
    end
endmodule : tcp_fifo

// File: hw/tcp_host.sv
`timescale 1ns/1ps
module tcp_host (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Bus
    tcp_i2c_if.host         bus,
    // Command
    input  wire logic       fast_mode,
    input  wire logic [6:0] dev_addr,
    input  wire logic       cmd_valid,
    input  wire logic       cmd_read,
    input  wire logic [7:0] cmd_reg,
    input  wire logic [7:0] cmd_len,
    output logic            cmd_ready,
    // Write data in
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_valid,
    output logic            wr_ready,
    // Read data out
    output logic [7:0]      rd_data,
    output logic            rd_valid,
    input  wire logic       rd_ready,
    // Status
    output logic            nack_err
);
    typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_ACK, H_RSTART, H_STOP} tcp_hst_t;
    tcp_hst_t    st_ff;
    logic [7:0]  div_ff;
    logic [1:0]  ph_ff;
    logic [3:0]  bit_ff;
    logic [7:0]  sh_ff;
    logic [1:0]  stage_ff;
    logic        rd_ff;
    logic [7:0]  left_ff;
    logic        scl_oe_ff;
    logic        sda_oe_ff;
    logic        err_ff;
    logic        rdy_ff;
    logic        fin_valid;
    logic        fin_ready;
    logic        wpop_ff;
    // =========================================================
    // Quarter-bit enable, rate 100 or 400 kbit/s
    // =========================================================
    wire [7:0] qdiv = fast_mode ? 8'(tcp_pkg::FAST_QDIV - 1) : 8'(tcp_pkg::STD_QDIV - 1);
    wire       q    = (div_ff == 8'h00);
    // Only read data bytes leave the data line to the device
    wire       bw   = (stage_ff != 2'h2);
    wire [7:0] nxt_left = left_ff - 8'h01;
    // Read data buffer, stalls the clock when full
    tcp_fifo #(.W(8), .D(tcp_pkg::FIFO_DEPTH), .AW(tcp_pkg::FIFO_AW)) u_rxq (
        .clk(clk), .sys_rst(sys_rst),
        .in_data(sh_ff), .in_valid(fin_valid), .in_ready(fin_ready),
        .out_data(rd_data), .out_valid(rd_valid), .out_ready(rd_ready)
    );
    assign fin_valid = st_ff == H_ACK && ph_ff == 2'h0 && q && stage_ff == 2'h2 && !wpop_ff;
    wire stall = fin_valid && !fin_ready;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_ff <= H_IDLE; div_ff <= 8'h00; ph_ff <= 2'h0; bit_ff <= 4'h0;
            sh_ff <= 8'h00; stage_ff <= 2'h0; rd_ff <= 1'b0; left_ff <= 8'h00;
            scl_oe_ff <= 1'b1; sda_oe_ff <= 1'b1; err_ff <= 1'b0; rdy_ff <= 1'b1;
            wpop_ff <= 1'b0;
        end else begin
            div_ff  <= q ? qdiv : div_ff - 8'h01;
            wpop_ff <= 1'b0;
            if (st_ff == H_IDLE) begin
                rdy_ff <= 1'b1;
                if (cmd_valid && rdy_ff) begin
                    rdy_ff <= 1'b0; st_ff <= H_START; ph_ff <= 2'h0; err_ff <= 1'b0;
                    rd_ff <= cmd_read; left_ff <= cmd_len; stage_ff <= 2'h0;
                    sh_ff <= {dev_addr, 1'b0};
                end
            end else if (q && !stall) begin
                ph_ff <= ph_ff + 2'h1;
                case (st_ff)
                    H_START: begin
                        if (ph_ff == 2'h1) sda_oe_ff <= 1'b0;
                        if (ph_ff == 2'h3) begin scl_oe_ff <= 1'b0; st_ff <= H_BIT; bit_ff <= 4'h0; end
                    end
                    H_BIT: begin
                        if (ph_ff == 2'h0) sda_oe_ff <= bw ? sh_ff[7] : 1'b1;
                        if (ph_ff == 2'h1) scl_oe_ff <= 1'b1;
                        if (ph_ff == 2'h2) sh_ff <= {sh_ff[6:0], bus.sda};
                        if (ph_ff == 2'h3) begin
                            scl_oe_ff <= 1'b0;
                            bit_ff <= bit_ff + 4'h1;
                            if (bit_ff == 4'h7) st_ff <= H_ACK;
                        end
                    end
                    H_ACK: begin
                        if (ph_ff == 2'h0) sda_oe_ff <= bw ? 1'b1 : (nxt_left == 8'h00);
                        if (ph_ff == 2'h1) scl_oe_ff <= 1'b1;
                        if (ph_ff == 2'h2 && bw && bus.sda) err_ff <= 1'b1;
                        if (ph_ff == 2'h3) begin
                            scl_oe_ff <= 1'b0; st_ff <= H_BIT; bit_ff <= 4'h0;
                            if (err_ff) st_ff <= H_STOP;
                            else if (stage_ff == 2'h0) begin stage_ff <= 2'h1; sh_ff <= cmd_reg; end
                            else if (stage_ff == 2'h1 && rd_ff) st_ff <= H_RSTART;
                            else if (stage_ff == 2'h3 && rd_ff) stage_ff <= 2'h2;
                            else if (left_ff == 8'h00 || (stage_ff == 2'h2 && nxt_left == 8'h00)) st_ff <= H_STOP;
                            else if (stage_ff == 2'h2) left_ff <= nxt_left;
                            else if (wr_valid) begin
                                stage_ff <= 2'h1; sh_ff <= wr_data; left_ff <= nxt_left; wpop_ff <= 1'b1;
                            end else st_ff <= H_STOP;
                        end
                    end
                    H_RSTART: begin
                        if (ph_ff == 2'h0) sda_oe_ff <= 1'b1;
                        if (ph_ff == 2'h1) scl_oe_ff <= 1'b1;
                        if (ph_ff == 2'h2) sda_oe_ff <= 1'b0;
                        if (ph_ff == 2'h3) begin
                            scl_oe_ff <= 1'b0; st_ff <= H_BIT; bit_ff <= 4'h0;
                            stage_ff <= 2'h3; sh_ff <= {dev_addr, 1'b1};
                        end
                    end
                    H_STOP: begin
                        if (ph_ff == 2'h0) sda_oe_ff <= 1'b0;
                        if (ph_ff == 2'h1) scl_oe_ff <= 1'b1;
                        if (ph_ff == 2'h3) begin sda_oe_ff <= 1'b1; st_ff <= H_IDLE; end
                    end
                    default: st_ff <= H_IDLE;
                endcase
            end
        end
    end
    assign bus.scl_o_n_oe    = scl_oe_ff;
    assign bus.sda_host_oe_n = sda_oe_ff;
    assign cmd_ready = rdy_ff;
    assign wr_ready  = wpop_ff;
    assign nack_err  = err_ff;
endmodule : tcp_host

// File: dv/tcp_i2c_properties.sv
`timescale 1ns/1ps
// ==========================================
// Bus line checks
module tcp_i2c_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bus lines
    input wire logic scl_o_n_oe,
    input wire logic sda_host_oe_n,
    input wire logic sda_dev_oe_n,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [11:0] low_cnt_ff;
    logic [11:0] nxt_low_cnt;
    assign nxt_low_cnt = sda_dev_oe_n ? 12'h000 : low_cnt_ff + 12'h001;
    always_ff @(posedge clk) begin
        low_cnt_ff <= sys_rst ? 12'h000 : nxt_low_cnt;
    end
    property p_rst_rel; $fell(sys_rst) |-> sda_dev_oe_n && sda_host_oe_n && scl_o_n_oe; endproperty
    a_rst_rel: assert property (p_rst_rel) else $error("bus not released after reset");
    property p_dev_edge; $changed(sda_dev_oe_n) |-> !scl; endproperty
    a_dev_edge: assert property (p_dev_edge) else $error("device changed data while clock high");
    property p_slave_only; $changed(sda) && scl && $past(scl) |-> sda_dev_oe_n; endproperty
    a_slave_only: assert property (p_slave_only) else $error("device made a start or stop");
    property p_scl_high; $rose(scl) |-> scl[*8]; endproperty
    a_scl_high: assert property (p_scl_high) else $error("clock high phase too short");
    property p_scl_low; $fell(scl) |-> !scl[*8]; endproperty
    a_scl_low: assert property (p_scl_low) else $error("clock low phase too short");
    property p_start_rel; $fell(sda) && scl |=> sda_dev_oe_n[*2]; endproperty
    a_start_rel: assert property (p_start_rel) else $error("device drove data after start");
    property p_stop_rel; $rose(sda) && scl && $past(scl) |=> sda_dev_oe_n[*8]; endproperty
    a_stop_rel: assert property (p_stop_rel) else $error("device drove data after stop");
    property p_low_max; low_cnt_ff < 12'hFA0; endproperty
    a_low_max: assert property (p_low_max) else $error("device held data low too long");
endmodule : tcp_i2c_properties

// File: dv/i2c_slave_register_port_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin errors++; $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module i2c_slave_register_port_tb;
    logic        clk = 1'b0, sys_rst = 1'b1, nvm_addr_valid = 1'b0, phase_tick = 1'b0, fast_mode = 1'b1;
    logic        cmd_valid = 1'b0, cmd_read = 1'b0, cmd_ready, wr_ready, rd_valid, nack_err, interrupt_output_n;
    logic        rd_ready = 1'b0, stall = 1'b0;
    logic [6:0]  nvm_addr = 7'h00, dev_addr = tcp_pkg::DEF_SLAVE_ADDR;
    logic [7:0]  irq_events = 8'h00, cmd_reg = 8'h00, cmd_len = 8'h00, cap_stat, gpi_stat, spm_stat, rd_data, ev;
    logic [7:0]  mon_exp;
    logic [7:0]  op_mode, gpo_ctrl, gpp_id, gpp_intensity, spm_cfg, spm_base, soft_reset, wbuf [8];
    logic [15:0] wheel_pos, spm_key;
    logic [7:0]  exp_q [$];
    int          errors = 0, num_checks = 0, wr_idx = 0;
    wire  [47:0] ctl = {spm_base, spm_cfg, gpp_intensity, gpp_id, gpo_ctrl, op_mode};
    wire  [7:0]  wr_data = wbuf[wr_idx[2:0]];
    always #12.5 clk = ~clk;
    tcp_i2c_if u_tcp_i2c_if ();
    tcp_dev u_tcp_dev (.clk, .sys_rst, .bus(u_tcp_i2c_if), .nvm_addr_valid, .nvm_addr, .phase_tick, .irq_events,
        .cap_stat, .wheel_pos, .gpi_stat, .spm_stat, .op_mode, .gpo_ctrl, .gpp_id, .gpp_intensity, .spm_cfg,
        .spm_base, .spm_key, .soft_reset, .interrupt_output_n);
    tcp_host u_tcp_host (.clk, .sys_rst, .bus(u_tcp_i2c_if), .fast_mode, .dev_addr, .cmd_valid, .cmd_read,
        .cmd_reg, .cmd_len, .cmd_ready, .wr_data, .wr_valid(1'b1), .wr_ready, .rd_data, .rd_valid, .rd_ready,
        .nack_err);
    tcp_i2c_properties u_tcp_i2c_properties (.clk, .sys_rst, .scl_o_n_oe(u_tcp_i2c_if.scl_o_n_oe),
        .sda_host_oe_n(u_tcp_i2c_if.sda_host_oe_n), .sda_dev_oe_n(u_tcp_i2c_if.sda_dev_oe_n),
        .scl(u_tcp_i2c_if.scl), .sda(u_tcp_i2c_if.sda));
    // ==========================================
    // Drivers and monitor
    always @(posedge clk) begin
        if (wr_ready === 1'b1) wr_idx <= wr_idx + 1;
        if (!sys_rst && rd_valid === 1'b1 && rd_ready === 1'b1) begin
            mon_exp = exp_q.pop_front();
            `CHK("rd_data", mon_exp, rd_data)
        end
        #1 rd_ready = !stall && $urandom_range(1, 0);
    end
    task automatic xfer(input logic rd, input logic [7:0] r, input logic [7:0] n);
        @(posedge clk) #1;
        cmd_read = rd;
        cmd_reg = r;
        cmd_len = n;
        wr_idx = 0;
        cmd_valid = 1'b1;
        do @(posedge clk); while (cmd_ready !== 1'b1);
        #1 cmd_valid = 1'b0;
        repeat (4) @(posedge clk);
        while (cmd_ready !== 1'b1) @(posedge clk);
        repeat (8) @(posedge clk);
        #1;
    endtask : xfer
    task automatic end_sim();
        if (exp_q.size() != 0) errors++;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    // ==========================================
    // Tests
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        $display("watchdog expired");
        end_sim();
    end
    initial begin
        void'($urandom(32'hCEA0));
        foreach (wbuf[i]) wbuf[i] = 8'($urandom);
        cap_stat = 8'($urandom);
        gpi_stat = 8'($urandom);
        spm_stat = 8'($urandom);
        wheel_pos = 16'($urandom);
        repeat (2) @(posedge clk);
        #1 sys_rst = 1'b0;
        xfer(1'b0, tcp_pkg::REG_OP_MODE, 8'h06);
        `CHK("op_mode", 8'h00, op_mode)
        @(posedge clk) #1 phase_tick = 1'b1;
        @(posedge clk) #1 phase_tick = 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 6; i++) `CHK("controls", wbuf[i], ctl[i*8+:8])
        xfer(1'b0, tcp_pkg::REG_KEY_MSB, 8'h02);
        xfer(1'b0, tcp_pkg::REG_SOFT_RST, 8'h01);
        @(posedge clk) #1 phase_tick = 1'b1;
        @(posedge clk) #1 phase_tick = 1'b0;
        `CHK("spm_key", {wbuf[0], wbuf[1]}, spm_key)
        `CHK("soft_reset", wbuf[0], soft_reset)
        $display("write test done");
        xfer(1'b0, tcp_pkg::REG_GPI_STAT, 8'h02);
        ev = (8'($urandom) & 8'h7B) | 8'h01;
        @(posedge clk) #1 irq_events = ev;
        @(posedge clk) #1 irq_events = 8'h00;
        repeat (2) @(posedge clk);
        `CHK("irq_n", 1'b0, interrupt_output_n)
        exp_q = {ev, cap_stat, 8'h00, wheel_pos[15:8], wheel_pos[7:0], 8'h00, 8'h00, gpi_stat, spm_stat};
        xfer(1'b1, tcp_pkg::REG_IRQ_SRC, 8'h09);
        `CHK("irq_n", 1'b1, interrupt_output_n)
        $display("status test done");
        stall = 1'b1;
        for (int i = 0; i < 16; i++) exp_q.push_back(i < 6 ? wbuf[i] : 8'h00);
        xfer(1'b1, tcp_pkg::REG_OP_MODE, 8'h10);
        `CHK("fifo_full", 16, exp_q.size())
        stall = 1'b0;
        for (int i = 0; i < 600 && exp_q.size() != 0; i++) @(posedge clk);
        $display("fifo test done");
        fast_mode = 1'b0;
        exp_q.push_back(wheel_pos[15:8]);
        xfer(1'b1, tcp_pkg::REG_POS_MSB, 8'h01);
        fast_mode = 1'b1;
        dev_addr = tcp_pkg::DEF_SLAVE_ADDR ^ 7'h01;
        xfer(1'b0, tcp_pkg::REG_OP_MODE, 8'h01);
        `CHK("nack_err", 1'b1, nack_err)
        nvm_addr = dev_addr;
        nvm_addr_valid = 1'b1;
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 sys_rst = 1'b0;
        exp_q.push_back(8'h00);
        xfer(1'b1, tcp_pkg::REG_OP_MODE, 8'h01);
        `CHK("nack_err", 1'b0, nack_err)
        $display("address test done");
        end_sim();
    end
endmodule : i2c_slave_register_port_tb
